/* File: core/mag_sensor_port.sv */
// Sensor end of the link: target port with pointer, results and control.
//
// Function
// - Detect start and stop on the bus.
// - Bytes are eight bits, MSB first, plus acknowledge.
// - Controller sends address then direction bit.
// - Answer only to address 0110000.
// - First byte after write address loads pointer.
// - Acknowledge own address on ninth clock.
// - Pointer then data writes or repeated-start read.
// - Pointer increments after every data byte.
// - Stop or new start ends current transfer.
// - Control write 00100001 starts one measurement.
// - Status bit 1 flags measurement done.
// - Controller reads results from pointer zero.
// - Bytes 0-5: upper bytes of x, y, z.
// - Bytes 6-8: low bits, 18 or 20 bit.
// - Controller acknowledges all but last byte.
// - Missing acknowledge makes device release SDA.
// - Register 29H: z self-test reference, read/write.
// - Register 39H: read-only part identification.
// - Control register lives at 1BH.
// - Control write 00001000 starts set pulse.
// - Status register lives at 18H.
`timescale 1ns/1ps
`default_nettype none
module mag_sensor_port
  import mag_link_pkg::*;
#(
  // Arbitrary identification value.
  parameter logic [7:0] PART_ID = 8'hA5,
  parameter logic [7:0] Z_SELFTEST_FACTORY = 8'h00
) (
  input wire logic i_clock,
  input wire logic i_reset,
  mag_link_if.device link,
  input wire logic [19:0] i_x_result,
  input wire logic [19:0] i_y_result,
  input wire logic [19:0] i_z_result,
  input wire logic i_result_valid,
  input wire logic i_resolution_20,
  output logic o_measure_start,
  output logic o_set_pulse,
  output logic o_reset_pulse,
  output logic o_auto_magnetize_enable,
  output logic [7:0] o_z_selftest_reference
);

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDRESS,
    D_ACK_OUT,
    D_WRITE,
    D_READ,
    D_ACK_IN
  } dev_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    dev_state_t state;
    logic [3:0] count;
    logic [7:0] shift;
    logic reading;
    logic ptr_loaded;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic done;
    logic auto_magnetize_enable;
    logic [7:0] z_selftest_reference;
    logic [19:0] x;
    logic [19:0] y;
    logic [19:0] z;
    logic measure_start;
    logic set_pulse;
    logic reset_pulse;
  } dev_regs_t;

  dev_regs_t state_reg;
  dev_regs_t state_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Low byte of an axis; 18-bit mode only carries bits 3 and 2.
  function automatic logic [7:0] low_byte(input logic [19:0] v,
                                          input logic wide);
    low_byte = wide ? {v[3:0], 4'h0} : {v[3:2], 6'h00};
  endfunction : low_byte

  function automatic logic [7:0] read_byte(input dev_regs_t r,
                                           input logic wide);
    case (r.ptr)
      REG_X_HIGH: read_byte = r.x[19:12];
      REG_X_MID: read_byte = r.x[11:4];
      REG_Y_HIGH: read_byte = r.y[19:12];
      REG_Y_MID: read_byte = r.y[11:4];
      REG_Z_HIGH: read_byte = r.z[19:12];
      REG_Z_MID: read_byte = r.z[11:4];
      REG_X_LOW: read_byte = low_byte(r.x, wide);
      REG_Y_LOW: read_byte = low_byte(r.y, wide);
      REG_Z_LOW: read_byte = low_byte(r.z, wide);
      REG_STATUS1: read_byte = 8'(r.done) << STATUS_DONE_BIT;
      REG_Z_SELFTEST_REF: read_byte = r.z_selftest_reference;
      REG_PART_ID: read_byte = PART_ID;
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // Only the second synchroniser stage and its delayed copy feed logic.
  assign scl_rise = state_reg.scl_s2 && !state_reg.scl_p;
  assign scl_fall = !state_reg.scl_s2 && state_reg.scl_p;
  assign bus_start = state_reg.scl_s2 && state_reg.scl_p &&
                     state_reg.sda_p && !state_reg.sda_s2;
  assign bus_stop = state_reg.scl_s2 && state_reg.scl_p &&
                    !state_reg.sda_p && state_reg.sda_s2;

  always_comb begin
    state_next = state_reg;
    state_next.scl_s1 = link.scl;
    state_next.scl_s2 = state_reg.scl_s1;
    state_next.scl_p = state_reg.scl_s2;
    state_next.sda_s1 = link.sda;
    state_next.sda_s2 = state_reg.sda_s1;
    state_next.sda_p = state_reg.sda_s2;
    state_next.measure_start = 1'b0;
    state_next.set_pulse = 1'b0;
    state_next.reset_pulse = 1'b0;

    if (bus_start) begin
      // A repeated start keeps the pointer so a read can follow it.
      state_next.state = D_ADDRESS;
      state_next.count = 4'h0;
      state_next.ptr_loaded = 1'b0;
      state_next.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      state_next.state = D_IDLE;
      state_next.sda_oe_n = 1'b1;
    end else begin
      case (state_reg.state)
        D_IDLE: begin
          state_next.sda_oe_n = 1'b1;
        end
        D_ADDRESS: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], state_reg.sda_s2};
            state_next.count = state_reg.count + 4'h1;
          end else if (scl_fall && state_reg.count == BITS_PER_BYTE) begin
            if (state_reg.shift[7:1] == TARGET_ADDR) begin
              state_next.reading = state_reg.shift[0];
              state_next.sda_oe_n = 1'b0;
              state_next.state = D_ACK_OUT;
            end else begin
              state_next.state = D_IDLE;
            end
          end
        end
        D_ACK_OUT: begin
          if (scl_fall) begin
            state_next.count = 4'h0;
            if (state_reg.reading) begin
              state_next.shift = read_byte(state_reg, i_resolution_20);
              state_next.sda_oe_n = state_next.shift[7];
              state_next.shift = {state_next.shift[6:0], 1'b0};
              state_next.state = D_READ;
            end else begin
              state_next.sda_oe_n = 1'b1;
              state_next.state = D_WRITE;
            end
          end
        end
        D_WRITE: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], state_reg.sda_s2};
            state_next.count = state_reg.count + 4'h1;
          end else if (scl_fall && state_reg.count == BITS_PER_BYTE) begin
            state_next.sda_oe_n = 1'b0;
            state_next.state = D_ACK_OUT;
            if (!state_reg.ptr_loaded) begin
              state_next.ptr = state_reg.shift;
              state_next.ptr_loaded = 1'b1;
            end else begin
              state_next.ptr = state_reg.ptr + 8'h01;
              case (state_reg.ptr)
                REG_CONTROL0: begin
                  state_next.auto_magnetize_enable =
                    state_reg.shift[CTRL_AUTO_BIT];
                  if (state_reg.shift[CTRL_TRIGGER_BIT]) begin
                    state_next.measure_start = 1'b1;
                    state_next.done = 1'b0;
                  end
                  state_next.set_pulse =
                    state_reg.shift[CTRL_SET_BIT];
                  state_next.reset_pulse = state_reg.shift[CTRL_RESET_BIT];
                end
                REG_Z_SELFTEST_REF: begin
                  state_next.z_selftest_reference = state_reg.shift;
                end
                default: begin
                  // Read-only and unused numbers still take the
                  // acknowledge but store nothing.
                  state_next.ptr = state_reg.ptr + 8'h01;
                end
              endcase
            end
          end
        end
        D_READ: begin
          if (scl_rise) begin
            state_next.count = state_reg.count + 4'h1;
          end else if (scl_fall) begin
            if (state_reg.count == BITS_PER_BYTE) begin
              state_next.sda_oe_n = 1'b1;
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.state = D_ACK_IN;
            end else begin
              state_next.sda_oe_n = state_reg.shift[7];
              state_next.shift = {state_reg.shift[6:0], 1'b0};
            end
          end
        end
        D_ACK_IN: begin
          if (scl_rise) begin
            state_next.nack = state_reg.sda_s2;
          end else if (scl_fall) begin
            if (state_reg.nack) begin
              state_next.sda_oe_n = 1'b1;
              state_next.state = D_IDLE;
            end else begin
              state_next.count = 4'h0;
              state_next.shift = read_byte(state_reg, i_resolution_20);
              state_next.sda_oe_n = state_next.shift[7];
              state_next.shift = {state_next.shift[6:0], 1'b0};
              state_next.state = D_READ;
            end
          end
        end
        default: begin
          state_next.state = D_IDLE;
          state_next.sda_oe_n = 1'b1;
        end
      endcase
    end

    // New results win over a trigger that clears the flag in this cycle.
    if (i_result_valid) begin
      state_next.x = i_x_result;
      state_next.y = i_y_result;
      state_next.z = i_z_result;
      state_next.done = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= '0;
      state_reg.scl_s1 <= 1'b1;
      state_reg.scl_s2 <= 1'b1;
      state_reg.scl_p <= 1'b1;
      state_reg.sda_s1 <= 1'b1;
      state_reg.sda_s2 <= 1'b1;
      state_reg.sda_p <= 1'b1;
      state_reg.state <= D_IDLE;
      state_reg.sda_oe_n <= 1'b1;
      state_reg.z_selftest_reference <= Z_SELFTEST_FACTORY;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe_n = state_reg.sda_oe_n;
  assign o_measure_start = state_reg.measure_start;
  assign o_set_pulse = state_reg.set_pulse;
  assign o_reset_pulse = state_reg.reset_pulse;
  assign o_auto_magnetize_enable = state_reg.auto_magnetize_enable;
  assign o_z_selftest_reference = state_reg.z_selftest_reference;

endmodule : mag_sensor_port
`default_nettype wire

/* File: core/mag_link_pkg.sv */
// Shared constants for the magnetometer serial link, both ends.
package mag_link_pkg;
  // Link framing.
  localparam logic [6:0] TARGET_ADDR = 7'h30;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Register numbers inside the sensor.
  localparam logic [7:0] REG_X_HIGH = 8'h00;
  localparam logic [7:0] REG_X_MID = 8'h01;
  localparam logic [7:0] REG_Y_HIGH = 8'h02;
  localparam logic [7:0] REG_Y_MID = 8'h03;
  localparam logic [7:0] REG_Z_HIGH = 8'h04;
  localparam logic [7:0] REG_Z_MID = 8'h05;
  localparam logic [7:0] REG_X_LOW = 8'h06;
  localparam logic [7:0] REG_Y_LOW = 8'h07;
  localparam logic [7:0] REG_Z_LOW = 8'h08;
  localparam logic [7:0] REG_STATUS1 = 8'h18;
  localparam logic [7:0] REG_CONTROL0 = 8'h1B;
  localparam logic [7:0] REG_Z_SELFTEST_REF = 8'h29;
  localparam logic [7:0] REG_PART_ID = 8'h39;
  // Field positions.
  localparam int STATUS_DONE_BIT = 1;
  localparam int CTRL_TRIGGER_BIT = 0;
  localparam int CTRL_SET_BIT = 3;
  localparam int CTRL_RESET_BIT = 4;
  localparam int CTRL_AUTO_BIT = 5;
  // Host controller registers, byte addresses on APB.
  localparam logic [7:0] HOST_COMMAND = 8'h00;
  localparam logic [7:0] HOST_TX_DATA = 8'h04;
  localparam logic [7:0] HOST_RX_DATA = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0C;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_NACK = 4;
  localparam int CMD_WIDTH = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACKED = 1;
  // Link clock made by the host divider.
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 160;
  localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLOCK_PERIOD_NS);
endpackage : mag_link_pkg

/* File: core/mag_link_if.sv */
// Two-wire open-drain link joining the host controller and the sensor port.
`timescale 1ns/1ps
`default_nettype none
interface mag_link_if;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // Open drain: a line is low when any enabled driver pulls it low.
  assign scl = !(!host_scl_oe_n && !host_scl_out);
  assign sda = !((!host_sda_oe_n && !host_sda_out) ||
                 (!dev_sda_oe_n && !dev_sda_out));
  modport host (output host_scl_out, output host_scl_oe_n,
                output host_sda_out, output host_sda_oe_n,
                input scl, input sda);
  modport device (output dev_sda_out, output dev_sda_oe_n,
                  input scl, input sda);
endinterface : mag_link_if
`default_nettype wire

/* File: core/mag_link_host.sv */
// Host end of the link: APB-driven byte controller making SCL and SDA.
`timescale 1ns/1ps
`default_nettype none
module mag_link_host
  import mag_link_pkg::*;
#(
  parameter int QUARTER_CYCLES = SCL_QUARTER_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  mag_link_if.host link,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_BITS,
    H_STOP
  } host_state_t;

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    host_state_t state;
    logic [1:0] phase;
    logic [7:0] divider;
    logic [3:0] bit_index;
    logic [7:0] tx_shift;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [CMD_WIDTH-1:0] command;
    logic acked;
    logic scl_oe_n;
    logic sda_oe_n;
    logic [31:0] prdata;
  } host_regs_t;

  host_regs_t state_reg;
  host_regs_t state_next;
  logic tick;

  // Start first, then the byte, then stop, as the command bits ask.
  function automatic host_state_t next_step(input logic [CMD_WIDTH-1:0] c);
    if (c[CMD_START]) next_step = H_START;
    else if (c[CMD_WRITE] || c[CMD_READ]) next_step = H_BITS;
    else if (c[CMD_STOP]) next_step = H_STOP;
    else next_step = H_IDLE;
  endfunction : next_step

  assign tick = state_reg.divider == 8'(QUARTER_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    state_next.sda_s1 = link.sda;
    state_next.sda_s2 = state_reg.sda_s1;

    if (i_psel && !i_penable) begin
      case (i_paddr)
        HOST_COMMAND: state_next.prdata = 32'(state_reg.command);
        HOST_TX_DATA: state_next.prdata = 32'(state_reg.tx_data);
        HOST_RX_DATA: state_next.prdata = 32'(state_reg.rx_data);
        HOST_STATUS: state_next.prdata =
          32'({state_reg.acked, state_reg.state != H_IDLE});
        default: state_next.prdata = 32'h0000_0000;
      endcase
    end

    if (state_reg.state == H_IDLE) begin
      state_next.divider = 8'h00;
      state_next.phase = 2'h0;
      if (i_psel && i_penable && i_pwrite) begin
        if (i_paddr == HOST_TX_DATA) state_next.tx_data = i_pwdata[7:0];
        if (i_paddr == HOST_COMMAND) begin
          state_next.command = i_pwdata[CMD_WIDTH-1:0];
          state_next.state = next_step(i_pwdata[CMD_WIDTH-1:0]);
          state_next.bit_index = 4'h0;
          state_next.tx_shift = state_reg.tx_data;
        end
      end
    end else begin
      state_next.divider = tick ? 8'h00 : state_reg.divider + 8'h01;
      if (tick) begin
        state_next.phase = state_reg.phase + 2'h1;
        case (state_reg.state)
          H_START: begin
            case (state_reg.phase)
              2'h0: state_next.sda_oe_n = 1'b1;
              2'h1: state_next.scl_oe_n = 1'b1;
              2'h2: state_next.sda_oe_n = 1'b0;
              default: begin
                state_next.scl_oe_n = 1'b0;
                state_next.command[CMD_START] = 1'b0;
                state_next.state = next_step(state_next.command);
              end
            endcase
          end
          H_BITS: begin
            case (state_reg.phase)
              2'h0: begin
                if (state_reg.bit_index < BITS_PER_BYTE)
                  state_next.sda_oe_n = state_reg.command[CMD_WRITE] ?
                                        state_reg.tx_shift[7] : 1'b1;
                else
                  state_next.sda_oe_n = state_reg.command[CMD_READ] ?
                                        state_reg.command[CMD_NACK] : 1'b1;
              end
              2'h1: state_next.scl_oe_n = 1'b1;
              2'h2: begin
                if (state_reg.bit_index < BITS_PER_BYTE)
                  state_next.rx_data = {state_reg.rx_data[6:0],
                                        state_reg.sda_s2};
                else
                  state_next.acked = !state_reg.sda_s2;
              end
              default: begin
                state_next.scl_oe_n = 1'b0;
                state_next.tx_shift = {state_reg.tx_shift[6:0], 1'b0};
                state_next.bit_index = state_reg.bit_index + 4'h1;
                if (state_reg.bit_index == BITS_PER_BYTE) begin
                  state_next.sda_oe_n = 1'b1;
                  state_next.command[CMD_WRITE] = 1'b0;
                  state_next.command[CMD_READ] = 1'b0;
                  state_next.state = next_step(state_next.command);
                end
              end
            endcase
          end
          H_STOP: begin
            case (state_reg.phase)
              2'h0: state_next.sda_oe_n = 1'b0;
              2'h1: state_next.scl_oe_n = 1'b1;
              2'h2: state_next.sda_oe_n = 1'b1;
              default: begin
                state_next.command[CMD_STOP] = 1'b0;
                state_next.state = H_IDLE;
              end
            endcase
          end
          default: state_next.state = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= '0;
      state_reg.sda_s1 <= 1'b1;
      state_reg.sda_s2 <= 1'b1;
      state_reg.state <= H_IDLE;
      state_reg.scl_oe_n <= 1'b1;
      state_reg.sda_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe_n = state_reg.scl_oe_n;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe_n = state_reg.sda_oe_n;
  assign o_prdata = state_reg.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

endmodule : mag_link_host
`default_nettype wire

/* File: test/mag_link_chk.sv */
// Checker for the shared two-wire link: timing, framing and addressing.
`timescale 1ns/1ps
`default_nettype none
module mag_link_chk
  import mag_link_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  logic scl_q, sda_q, first, rise, start, stop, hit;
  logic [3:0] nbit;
  logic [7:0] shf;
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign hit = rise && first && nbit == 4'h8;
  // The slot count restarts at every start so the address byte is known.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      nbit <= 4'h0;
      shf <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        first <= 1'b1;
        nbit <= 4'h0;
      end else if (rise) begin
        nbit <= (nbit == 4'h9) ? 4'h1 : nbit + 4'h1;
        if (nbit < 4'h8)
          shf <= {shf[6:0], sda};
        if (nbit == 4'h9)
          first <= 1'b0;
      end
    end
  end
  property p_dev_edge;
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2);
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("sensor moved sda while scl high");
  property p_ack_hold;
    $fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("sensor drive too short");
  property p_start_hold;
    start |-> scl [*3];
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("scl fell too soon after start");
  property p_stop_hold;
    stop |-> sda [*3];
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("sda not held high after stop");
  property p_scl_high;
    $rose(scl) |-> scl [*4];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase too short");
  property p_addr_ack;
    hit && shf[7:1] == TARGET_ADDR |-> !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_addr_nak;
    hit && shf[7:1] != TARGET_ADDR |-> sda;
  endproperty
  a_addr_nak: assert property (p_addr_nak)
    else $error("foreign address acknowledged");
  property p_start_quiet;
    start |-> dev_sda_oe_n [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("sensor drives sda right after start");
  c_addr_ack: cover property (hit && !sda);
  c_dev_drive: cover property ($fell(dev_sda_oe_n) && !first);
  c_start: cover property (start);
endmodule : mag_link_chk
`default_nettype wire

/* File: test/magnetometer_i2c_register_port_test.sv */
// Bench joining the link host and the sensor port, with wire checks.
`timescale 1ns/1ps
`default_nettype none
module magnetometer_i2c_register_port_test
  import mag_link_pkg::*;
;
  // Arbitrary identification value and factory reference for this run.
  localparam logic [7:0] PART = 8'h3C;
  localparam logic [7:0] ZF = 8'h5C;
  localparam logic [4:0] CS = 5'(1 << CMD_START);
  localparam logic [4:0] CW = 5'(1 << CMD_WRITE);
  localparam logic [4:0] CR = 5'(1 << CMD_READ);
  localparam logic [4:0] CP = 5'(1 << CMD_STOP);
  localparam logic [4:0] CN = 5'(1 << CMD_NACK);
  logic i_clock, i_reset, psel, penable, pwrite, pready, pslverr;
  logic res_valid, res20, meas, set_p, rst_p, auto_en;
  logic [7:0] paddr, zref, b, e;
  logic [6:0] a7;
  logic [31:0] pwdata, prdata, st, v;
  logic [19:0] x_res, y_res, z_res;
  logic [8:0] wire_sh = 9'h000;
  logic [31:0] seed = 32'h4610;
  logic [7:0] ctl [3] = '{8'h21, 8'h08, 8'h10};
  int err_count = 0, checks = 0, n_meas = 0, n_set = 0, n_rst = 0;
  int m0, s0, r0;
  mag_link_if mag_link_if_i ();
  mag_link_host mag_link_host_i (
    .i_clock(i_clock), .i_reset(i_reset), .link(mag_link_if_i),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr));
  mag_sensor_port #(.PART_ID(PART), .Z_SELFTEST_FACTORY(ZF))
    mag_sensor_port_i (
    .i_clock(i_clock), .i_reset(i_reset), .link(mag_link_if_i),
    .i_x_result(x_res), .i_y_result(y_res), .i_z_result(z_res),
    .i_result_valid(res_valid), .i_resolution_20(res20),
    .o_measure_start(meas), .o_set_pulse(set_p), .o_reset_pulse(rst_p),
    .o_auto_magnetize_enable(auto_en), .o_z_selftest_reference(zref));
  mag_link_chk mag_link_chk_i (
    .i_clock(i_clock), .i_reset(i_reset),
    .dev_sda_oe_n(mag_link_if_i.dev_sda_oe_n),
    .scl(mag_link_if_i.scl), .sda(mag_link_if_i.sda));
  // Last nine bits on the wire: eight data bits then the acknowledge.
  always @(posedge mag_link_if_i.scl) begin
    wire_sh <= {wire_sh[7:0], mag_link_if_i.sda};
  end
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (meas === 1'b1) n_meas++;
    if (set_p === 1'b1) n_set++;
    if (rst_p === 1'b1) n_rst++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_byte(input int i, input logic r20);
    logic [19:0] w;
    w = (i == 0 || i == 1 || i == 6) ? x_res :
        (i == 2 || i == 3 || i == 7) ? y_res : z_res;
    if (i < 6)
      return (i % 2 == 0) ? w[19:12] : w[11:4];
    return r20 ? {w[3:0], 4'h0} : {w[3:2], 6'h00};
  endfunction : exp_byte
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    q = prdata;
    check({7'h00, pslverr}, 8'h00);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xfer(input logic [4:0] c, input logic [7:0] tx,
                      output logic [31:0] s);
    logic [31:0] q;
    apb(1'b1, HOST_TX_DATA, {24'h000000, tx}, q);
    apb(1'b1, HOST_COMMAND, {27'h0000000, c}, q);
    do begin
      apb(1'b0, HOST_STATUS, 32'h00000000, s);
    end while (s[STAT_BUSY] !== 1'b0);
  endtask : xfer
  task automatic ack_is(input logic a);
    check({7'h00, st[STAT_ACKED]}, {7'h00, a});
  endtask : ack_is
  task automatic stop_idle();
    xfer(CP, 8'h00, st);
    check({6'h00, mag_link_if_i.scl, mag_link_if_i.sda}, 8'h03);
  endtask : stop_idle
  task automatic wr_begin(input logic [7:0] ptr);
    xfer(CS | CW, {TARGET_ADDR, 1'b0}, st);
    ack_is(1'b1);
    xfer(CW, ptr, st);
    ack_is(1'b1);
  endtask : wr_begin
  task automatic wr_byte(input logic [7:0] d, input logic last);
    xfer(last ? (CW | CP) : CW, d, st);
    ack_is(1'b1);
  endtask : wr_byte
  task automatic read_byte(input logic last, output logic [7:0] got);
    logic [31:0] q;
    xfer(last ? (CR | CN) : CR, 8'h00, st);
    check({7'h00, wire_sh[0]}, {7'h00, last});
    apb(1'b0, HOST_RX_DATA, 32'h00000000, q);
    got = q[7:0];
  endtask : read_byte
  task automatic rd_begin(input logic [7:0] ptr);
    wr_begin(ptr);
    xfer(CS | CW, {TARGET_ADDR, 1'b1}, st);
    ack_is(1'b1);
  endtask : rd_begin
  task automatic rd_one(input logic [7:0] ptr, input logic [7:0] x,
                        input logic [7:0] m);
    logic [7:0] got;
    rd_begin(ptr);
    read_byte(1'b1, got);
    check(got & m, x & m);
    check(wire_sh[8:1] & m, x & m);
    stop_idle();
  endtask : rd_one
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (90000) @(posedge i_clock);
    err_count++;
    final_report();
  end
  initial begin
    {i_reset, psel, penable, pwrite, res_valid, res20} = 6'b100000;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {x_res, y_res, z_res} = 60'h0;
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    check(zref, ZF);
    apb(1'b0, 8'h10, 32'h00000000, v);
    check(v[7:0], 8'h00);
    rd_one(REG_Z_SELFTEST_REF, ZF, 8'hFF);
    rd_one(REG_PART_ID, PART, 8'hFF);
    rd_one(REG_STATUS1, 8'h00, 8'h02);
    v = rnd();
    wr_begin(8'h28);
    wr_byte(v[15:8], 1'b0);
    wr_byte(v[7:0], 1'b1);
    rd_one(REG_Z_SELFTEST_REF, v[7:0], 8'hFF);
    check(zref, v[7:0]);
    wr_begin(REG_PART_ID);
    wr_byte(~PART, 1'b1);
    rd_one(REG_PART_ID, PART, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      a7 = (k < 2) ? TARGET_ADDR ^ 7'(k + 1) : v[6:0];
      if (a7 == TARGET_ADDR) a7 = ~a7;
      xfer(CS | CW, {a7, 1'b0}, st);
      ack_is(1'b0);
      stop_idle();
    end
    for (int r = 0; r < 2; r++) begin
      v = rnd();
      x_res <= (r == 0) ? 20'hFFFFF : v[19:0];
      y_res <= (r == 0) ? 20'h00000 : v[31:12];
      z_res <= v[25:6];
      res20 <= r[0];
      res_valid <= 1'b1;
      @(posedge i_clock);
      res_valid <= 1'b0;
      rd_one(REG_STATUS1, 8'h02, 8'h02);
      rd_begin(REG_X_HIGH);
      for (int i = 0; i < 9; i++) begin
        read_byte(i == 8, b);
        e = exp_byte(i, r[0]);
        check(b, e);
        check(wire_sh[8:1], e);
      end
      stop_idle();
    end
    foreach (ctl[k]) begin
      m0 = n_meas;
      s0 = n_set;
      r0 = n_rst;
      wr_begin(REG_CONTROL0);
      wr_byte(ctl[k], 1'b1);
      check(8'(n_meas - m0), {7'h00, ctl[k][0]});
      check(8'(n_set - s0), {7'h00, ctl[k][3]});
      check(8'(n_rst - r0), {7'h00, ctl[k][4]});
      check({7'h00, auto_en}, {7'h00, ctl[k][5]});
    end
    rd_one(REG_STATUS1, 8'h00, 8'h02);
    final_report();
  end
endmodule : magnetometer_i2c_register_port_test
`default_nettype wire
